//--- verilog/ecb_pkg.sv
// constants, register map and field layout of the event counter block
package ecb_pkg;
    // ---------------------------------------------------------------
    // value range
    // ---------------------------------------------------------------
    localparam int          CW        = 14;
    localparam logic [13:0] CNT_MAX   = 14'h270f; // 9999
    localparam logic [13:0] CNT_ZERO  = 14'h0000;
    localparam logic [13:0] CNT_ONE   = 14'h0001;
    // ---------------------------------------------------------------
    // register offsets (byte addresses)
    // ---------------------------------------------------------------
    localparam logic [11:0] OFS_CTRL   = 12'h000;
    localparam logic [11:0] OFS_TARGET = 12'h004;
    localparam logic [11:0] OFS_LOAD   = 12'h008;
    localparam logic [11:0] OFS_STATUS = 12'h00c;
    // ---------------------------------------------------------------
    // control fields and reset values
    // ---------------------------------------------------------------
    localparam int          CTRL_DOWN  = 0;
    localparam int          CTRL_LATCH = 1;
    localparam int          CTRL_CSEL  = 2;  // 2 bits
    localparam int          CTRL_RSEL  = 4;
    localparam int          STAT_MATCH = 16;
    localparam logic [4:0]  CTRL_RST   = 5'h00;
    localparam logic [13:0] TARGET_RST = 14'h0000;
    localparam logic [13:0] LOAD_RST   = 14'h0000;
    // ---------------------------------------------------------------
    // edge selections
    // ---------------------------------------------------------------
    localparam logic [1:0]  CSEL_BOTH  = 2'h0;
    localparam logic [1:0]  CSEL_HIGH  = 2'h1;
    localparam logic [1:0]  CSEL_LOW   = 2'h2;
    localparam logic        RSEL_HIGH  = 1'b0;
    // pin index in the synchroniser
    localparam int          PIN_CNT    = 0;
    localparam int          PIN_CLR    = 1;
    localparam int          PIN_CERR   = 2;
    localparam int          PIN_RERR   = 3;
    localparam int          NPINS      = 4;
endpackage : ecb_pkg

//--- verilog/ecb_counter.sv
// event counter block with apb register file
//
// Summary of operation
// - up mode adds one per counted edge
// - down mode subtracts one per counted edge
// - match output on when count equals target
// - clear edge drops match, reloads load value
// - target setting holds 0 to 9999
// - load setting 0 to 9999, loaded at reset/clear
// - latching keeps match on until clear
// - non-latching match only while count equals target
// - count edge selection picks counted changes
// - count edges: both, rising or falling
// - clear edge: rising or falling
// - increment at 9999 wraps to 0
// - count error stops counting, clear error stops clear
module ecb_counter
    import ecb_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        count_input,
    input  wire logic        clear_input,
    input  wire logic        count_err,
    input  wire logic        clear_err,
    output logic             match_out,
    output logic      [13:0] count_value
);
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [13:0] ecb_clamp(input logic [31:0] v);
        ecb_clamp = (v > {18'h0, CNT_MAX}) ? CNT_MAX : v[13:0];
    endfunction : ecb_clamp

    function automatic logic ecb_mapped(input logic [11:0] a);
        ecb_mapped = (a == OFS_CTRL) || (a == OFS_TARGET) ||
                     (a == OFS_LOAD) || (a == OFS_STATUS);
    endfunction : ecb_mapped

    // ---------------------------------------------------------------
    // declarations
    // ---------------------------------------------------------------
    logic [NPINS-1:0] s1_r, s2_r, s3_r, filt_r, prev_r;
    logic [4:0]       ctrl_r;
    logic [13:0]      target_r, load_r, count_r, count_nxt;
    logic             match_r, match_nxt;
    logic             cnt_rise, cnt_fall, clr_rise, clr_fall;
    logic             cnt_edge, clr_edge, cnt_evt, clr_evt, eq;
    logic             wr_en, setup;

    // ---------------------------------------------------------------
    // three-stage pin synchroniser and agreement filter
    // ---------------------------------------------------------------
    // stage one feeds stage two only; level rises when 2 and 3 agree high, falls when 2 and 3 disagree, holds when both are low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r   <= '0;
            s2_r   <= '0;
            s3_r   <= '0;
            filt_r <= '0;
            prev_r <= '0;
        end else begin
            s1_r   <= {clear_err, count_err, clear_input, count_input};
            s2_r   <= s1_r;
            s3_r   <= s2_r;
            filt_r <= (filt_r & ~(s2_r ^ s3_r)) | (s3_r & ~(s2_r ^ s3_r));
            prev_r <= filt_r;
        end
    end

    // edge detection against the previous filtered sample
    assign cnt_rise = filt_r[PIN_CNT] & ~prev_r[PIN_CNT];
    assign cnt_fall = ~filt_r[PIN_CNT] & prev_r[PIN_CNT];
    assign clr_rise = filt_r[PIN_CLR] & ~prev_r[PIN_CLR];
    assign clr_fall = ~filt_r[PIN_CLR] & prev_r[PIN_CLR];

    // edge selection for count and clear inputs
    always_comb begin
        unique case (ctrl_r[CTRL_CSEL +: 2])
            CSEL_BOTH: cnt_edge = cnt_rise | cnt_fall;
            CSEL_HIGH: cnt_edge = cnt_rise;
            CSEL_LOW:  cnt_edge = cnt_fall;
            default:   cnt_edge = 1'b0; // unused code counts nothing
        endcase
    end
    assign clr_edge = (ctrl_r[CTRL_RSEL] == RSEL_HIGH) ? clr_rise
                                                      : clr_fall;
    // an input in error blocks only its own function
    assign cnt_evt = cnt_edge & ~filt_r[PIN_CERR];
    assign clr_evt = clr_edge & ~filt_r[PIN_RERR];
    assign eq      = (count_r == target_r);

    // ---------------------------------------------------------------
    // apb slave
    // ---------------------------------------------------------------
    assign setup = psel & ~penable;
    assign wr_en = psel & penable & pready & pwrite & ecb_mapped(paddr);

    // read data and response captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~ecb_mapped(paddr);
            if (setup && !pwrite) begin
                unique case (paddr)
                    OFS_CTRL:   prdata <= {27'h0, ctrl_r};
                    OFS_TARGET: prdata <= {18'h0, target_r};
                    OFS_LOAD:   prdata <= {18'h0, load_r};
                    OFS_STATUS: prdata <= {15'h0, match_r, 2'h0, count_r};
                    default:    prdata <= '0;
                endcase
            end
        end
    end

    // settings, values above 9999 clamp to 9999
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r   <= CTRL_RST;
            target_r <= TARGET_RST;
            load_r   <= LOAD_RST;
        end else if (wr_en) begin
            if (paddr == OFS_CTRL)   ctrl_r   <= pwdata[4:0];
            if (paddr == OFS_TARGET) target_r <= ecb_clamp(pwdata);
            if (paddr == OFS_LOAD)   load_r   <= ecb_clamp(pwdata);
        end
    end

    // ---------------------------------------------------------------
    // counter and match output
    // ---------------------------------------------------------------
    always_comb begin
        count_nxt = count_r;
        if (clr_evt) begin
            count_nxt = load_r;
        end else if (cnt_evt && !ctrl_r[CTRL_DOWN]) begin
            count_nxt = (count_r >= CNT_MAX) ? CNT_ZERO
                                             : count_r + CNT_ONE;
        end else if (cnt_evt) begin
            count_nxt = (count_r == CNT_ZERO) ? CNT_MAX
                                              : count_r - CNT_ONE;
        end
    end

    // match follows equality, or sticks when latching
    always_comb begin
        if (clr_evt)
            match_nxt = 1'b0;
        else if (ctrl_r[CTRL_LATCH])
            match_nxt = match_r | eq;
        else
            match_nxt = eq;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_r <= LOAD_RST; // power-up load
            match_r <= 1'b0;
        end else begin
            count_r <= count_nxt;
            match_r <= match_nxt;
        end
    end

    assign match_out   = match_r;
    assign count_value = count_r;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_up;
        cnt_evt && !clr_evt && !ctrl_r[CTRL_DOWN] && count_r < CNT_MAX
        |=> count_r == $past(count_r) + CNT_ONE;
    endproperty
    a_up: assert property (p_up) else $error("up count wrong");

    property p_down;
        cnt_evt && !clr_evt && ctrl_r[CTRL_DOWN] && count_r != CNT_ZERO
        |=> count_r == $past(count_r) - CNT_ONE;
    endproperty
    a_down: assert property (p_down) else $error("down count wrong");

    property p_eq_match;
        !clr_evt && eq |=> match_out;
    endproperty
    a_eq_match: assert property (p_eq_match)
        else $error("match missing at target");

    property p_clear;
        clr_evt |=> count_r == $past(load_r) && !match_out;
    endproperty
    a_clear: assert property (p_clear) else $error("clear failed");

    property p_range;
        target_r <= CNT_MAX && load_r <= CNT_MAX && count_r <= CNT_MAX;
    endproperty
    a_range: assert property (p_range)
        else $error("setting out of range");

    property p_latch;
        ctrl_r[CTRL_LATCH] && match_r && !clr_evt |=> match_out;
    endproperty
    a_latch: assert property (p_latch) else $error("latch dropped");

    property p_nolatch;
        !ctrl_r[CTRL_LATCH] && !eq |=> !match_out;
    endproperty
    a_nolatch: assert property (p_nolatch)
        else $error("match without equality");

    property p_wrap_up;
        cnt_evt && !clr_evt && !ctrl_r[CTRL_DOWN] && count_r == CNT_MAX
        |=> count_r == CNT_ZERO;
    endproperty
    a_wrap_up: assert property (p_wrap_up) else $error("no wrap to 0");

    property p_wrap_dn;
        cnt_evt && !clr_evt && ctrl_r[CTRL_DOWN] && count_r == CNT_ZERO
        |=> count_r == CNT_MAX;
    endproperty
    a_wrap_dn: assert property (p_wrap_dn)
        else $error("no wrap to 9999");

    property p_err;
        filt_r[PIN_CERR] && !clr_evt |=> $stable(count_r);
    endproperty
    a_err: assert property (p_err) else $error("count moved in error");

    property p_csel_high;
        ctrl_r[CTRL_CSEL +: 2] == CSEL_HIGH && cnt_fall |-> !cnt_evt;
    endproperty
    a_csel_high: assert property (p_csel_high)
        else $error("falling edge counted");

    c_clear: cover property (clr_evt ##1 match_out == 1'b0);
    c_wrap:  cover property (cnt_evt && count_r == CNT_MAX);
    c_latch: cover property (ctrl_r[CTRL_LATCH] && match_r && !eq);
    c_write: cover property (wr_en && paddr == OFS_TARGET);
endmodule : ecb_counter

//--- tb/ecb_src.sv
// far-side model driving the count and clear pins of the counter
module ecb_src (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic cnt_tgl,
    input  wire logic clr_tgl,
    output logic      count_input,
    output logic      clear_input
);
    timeunit 1ns;
    timeprecision 1ps;
    // each request flips a pin, which then holds until the next request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_input <= 1'b0;
            clear_input <= 1'b0;
        end else begin
            count_input <= count_input ^ cnt_tgl;
            clear_input <= clear_input ^ clr_tgl;
        end
    end
endmodule : ecb_src

//--- tb/tb_ecb_counter.sv
// self-checking bench of the event counter block
module tb_ecb_counter
    import ecb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel, penable, pwrite, cnt_tgl, clr_tgl, count_err, clear_err;
    logic        pready, pslverr, match_out, count_input, clear_input;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, seed;
    logic [13:0] count_value, c, tgt;
    logic [32:0] exp_q[$];
    int          n_errors = 0;
    int          samples_checked = 0;

    // free-running clock, 5 ns period
    always #2.5 pclk = ~pclk;

    ecb_counter uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .count_input, .clear_input,
        .count_err, .clear_err, .match_out, .count_value);
    ecb_src src (.pclk, .presetn, .cnt_tgl, .clr_tgl, .count_input,
        .clear_input);

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs

    task automatic check(input logic [32:0] seen, input logic [32:0] want);
        samples_checked++;
        if (seen !== want) begin
            n_errors++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, want);
        end
    endtask : check

    task automatic stop_test();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : stop_test

    // one apb transfer; reads leave their expected answer in the queue
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [32:0] e);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        if (!w) exp_q.push_back(e);
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        apb(1'b0, a, 32'h0, e);
    endtask : rd

    // pins and status read against the bench's own count
    task automatic rs(input logic m);
        check({18'h0, match_out, count_value}, {18'h0, m, c});
        rd(OFS_STATUS, {16'h0000, m, 2'h0, c});
    endtask : rs

    // n pin flips on count (k=0) or clear (k=1), each held 12 cycles
    task automatic flip(input logic k, input int n);
        repeat (n) begin
            @(posedge pclk);
            if (k) clr_tgl <= 1'b1;
            else cnt_tgl <= 1'b1;
            @(posedge pclk);
            cnt_tgl <= 1'b0;
            clr_tgl <= 1'b0;
            repeat (10) @(posedge pclk);
        end
    endtask : flip

    // compares each completed read with the oldest queued note
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite)
            check({pslverr, prdata},
                  exp_q.size() ? exp_q.pop_front() : 'x);
    end

    // cuts a hung run short
    initial begin
        #50000;
        n_errors++;
        stop_test();
    end

    // main sequence
    initial begin
        {psel, penable, pwrite, cnt_tgl, clr_tgl, count_err, clear_err} = '0;
        paddr = 12'h000;
        pwdata = 32'h0;
        seed = 32'h0000001a;
        c = CNT_ZERO;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        rd(OFS_CTRL, 33'h0);
        rd(OFS_LOAD, 33'h0);
        rs(1'b1);
        rd(12'h010, {1'b1, 32'h0});
        wr(OFS_TARGET, 32'h0000ffff);
        rd(OFS_TARGET, {19'h0, CNT_MAX});
        wr(OFS_LOAD, 32'h0000270e);
        wr(OFS_CTRL, 32'h0);
        flip(1'b1, 1);
        c = 14'h270e;
        rs(1'b0);
        flip(1'b0, 1);
        c = CNT_MAX;
        rs(1'b1);
        flip(1'b0, 1);
        c = CNT_ZERO;
        rs(1'b0);
        for (int s = 0; s < 4; s++) begin
            wr(OFS_CTRL, 32'(s) << 2);
            flip(1'b0, 2);
            c = c + 14'((s == 0) ? 2 : (s < 3));
            rs(1'b0);
        end
        tgt = c + CNT_ONE;
        wr(OFS_TARGET, 32'(tgt));
        wr(OFS_CTRL, 32'h02);
        flip(1'b0, 2);
        c = c + 14'h0002;
        rs(1'b1);
        wr(OFS_CTRL, 32'h12);
        flip(1'b1, 1);
        c = 14'h270e;
        rs(1'b0);
        flip(1'b1, 1);
        rs(1'b0);
        clear_err <= 1'b1;
        repeat (6) @(posedge pclk);
        flip(1'b0, 1);
        flip(1'b1, 1);
        c = CNT_MAX;
        rs(1'b0);
        clear_err <= 1'b0;
        count_err <= 1'b1;
        repeat (6) @(posedge pclk);
        flip(1'b0, 1);
        rs(1'b0);
        flip(1'b1, 2);
        c = 14'h270e;
        rs(1'b0);
        count_err <= 1'b0;
        wr(OFS_LOAD, 32'h0);
        wr(OFS_CTRL, 32'h11);
        flip(1'b1, 2);
        c = CNT_ZERO;
        rs(1'b0);
        flip(1'b0, 1);
        c = CNT_MAX;
        rs(1'b0);
        flip(1'b0, 1);
        c = 14'h270e;
        rs(1'b0);
        repeat (4) begin
            seed = xs(seed);
            c = 14'(seed % 32'd10000);
            wr(OFS_LOAD, 32'(c));
            flip(1'b1, 2);
            rs(c == tgt);
        end
        // mid-run reset reloads the power-up load value
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        c = CNT_ZERO;
        rs(1'b1);
        rd(OFS_LOAD, 33'h0);
        stop_test();
    end
endmodule : tb_ecb_counter
